/* File: common/shift_reg_pkg.sv */
package shift_reg_pkg;

    localparam int STAGE_COUNT = 4;
    localparam logic [3:0] STAGES_RESET = 4'h0;
    localparam logic STAGE_FOUR_INV_RESET = 1'h1;
    localparam int STAGE_ONE_POS = 0;
    localparam int STAGE_FOUR_POS = 3;

    typedef struct packed {
        logic j_in;
        logic k_in_n;
    } serial_pair_t;

    typedef enum logic [1:0] {
        MODE_LOAD = 2'h1,
        MODE_SHIFT = 2'h2
    } mode_t;

endpackage

/* File: rtl/input_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module input_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule
`default_nettype wire

/* File: rtl/parallel_shift_reg.sv */
// Operation
// RULE1: Four stages, each with its own parallel data input and output.
// RULE2: Shift_not_load low loads all four parallel data inputs.
// RULE3: Loaded values appear only after a rising clock edge.
// RULE4: Serial inputs are ignored during parallel load.
// RULE5: Shift_not_load high moves stage one to two, two to three, three to four.
// RULE6: While shifting, stage one takes its value from J and inverted K.
// RULE7: Stage one: 0/1 hold, 0/0 clear, 1/1 set, 1/0 toggle.
// RULE8: Clear low forces stages low, inverted output high, overriding everything. Code applies it only on a core_clk edge, after two sync flops.
// RULE9: Inverted output always equals the inverse of stage four.
// RULE10: Only two modes: parallel load and shift toward stage four.
// RULE11: Without clock edge or clear, all outputs keep their values.
// RULE12: Driving logic keeps inputs stable around edges, releases clear before edge.
`timescale 1ns/1ps
`default_nettype none

module parallel_shift_reg (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clear_n,
    input wire logic shift_not_load,
    input wire logic j_in,
    input wire logic k_in_n,
    input wire logic [3:0] data_in,
    output logic stage_one_out,
    output logic stage_two_out,
    output logic stage_three_out,
    output logic stage_four_out,
    output logic stage_four_out_inverted
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [7:0] sync_bus;
    logic [7:0] raw_bus;
    shift_reg_pkg::serial_pair_t serial_s;
    logic [3:0] data_s;
    logic mode_bit_s;
    logic clear_n_s;
    shift_reg_pkg::mode_t mode;

    assign raw_bus = {clear_n, shift_not_load, j_in, k_in_n, data_in};

    input_sync #(
        .WIDTH(8)
    ) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .async_in(raw_bus),
        .sync_out(sync_bus)
    );

    // Synced clear defaults low, so the register stays cleared after reset
    assign clear_n_s = sync_bus[7];
    assign mode_bit_s = sync_bus[6];
    assign serial_s = shift_reg_pkg::serial_pair_t'(sync_bus[5:4]);
    assign data_s = sync_bus[3:0];
    assign mode = mode_bit_s ? shift_reg_pkg::MODE_SHIFT : shift_reg_pkg::MODE_LOAD; // RULE10

    // ****************************************
    // Stage register
    // ****************************************
    logic [3:0] stages_q;
    logic [3:0] stages_d;
    logic first_d;

    // J-K behaviour of the first stage
    always_comb begin
        unique case ({serial_s.j_in, serial_s.k_in_n})
            2'h1: first_d = stages_q[shift_reg_pkg::STAGE_ONE_POS]; // RULE7
            2'h0: first_d = 1'h0; // RULE7
            2'h3: first_d = 1'h1; // RULE7
            2'h2: first_d = ~stages_q[shift_reg_pkg::STAGE_ONE_POS]; // RULE7
        endcase
    end

    always_comb begin
        unique case (mode)
            shift_reg_pkg::MODE_LOAD: stages_d = data_s; // RULE2 RULE4
            shift_reg_pkg::MODE_SHIFT: stages_d = {stages_q[2:0], first_d}; // RULE5 RULE6
            default: stages_d = stages_q;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin // RULE1 RULE3 RULE11
        if (!rst_n) begin
            stages_q <= shift_reg_pkg::STAGES_RESET;
        end else if (!clear_n_s) begin
            stages_q <= shift_reg_pkg::STAGES_RESET; // RULE8
        end else begin
            stages_q <= stages_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Inverted output registered from the same next value to stay exact
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stage_four_out_inverted <= shift_reg_pkg::STAGE_FOUR_INV_RESET;
        end else if (!clear_n_s) begin
            stage_four_out_inverted <= shift_reg_pkg::STAGE_FOUR_INV_RESET; // RULE8
        end else begin
            stage_four_out_inverted <= ~stages_d[shift_reg_pkg::STAGE_FOUR_POS]; // RULE9
        end
    end

    assign stage_one_out = stages_q[0];
    assign stage_two_out = stages_q[1];
    assign stage_three_out = stages_q[2];
    assign stage_four_out = stages_q[3];

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_shift_edge;
        clear_n_s && mode_bit_s;
    endsequence

    sequence s_load_edge;
        clear_n_s && !mode_bit_s;
    endsequence

    property p_load;
        @(posedge core_clk) disable iff (!rst_n)
        s_load_edge |=> stages_q == $past(data_s);
    endproperty
    a_load: assert property (p_load) else $error("parallel load mismatch"); // RULE2

    property p_load_no_serial;
        @(posedge core_clk) disable iff (!rst_n)
        s_load_edge |=> stage_one_out == $past(data_s[0]);
    endproperty
    a_load_no_serial: assert property (p_load_no_serial) else $error("serial leaked in load"); // RULE4

    property p_shift;
        @(posedge core_clk) disable iff (!rst_n)
        s_shift_edge |=> stages_q[3:1] == $past(stages_q[2:0]);
    endproperty
    a_shift: assert property (p_shift) else $error("shift mismatch"); // RULE5

    property p_jk;
        @(posedge core_clk) disable iff (!rst_n)
        s_shift_edge |=> stage_one_out == (($past(serial_s.j_in) && !$past(stage_one_out))
            || ($past(serial_s.k_in_n) && $past(stage_one_out)));
    endproperty
    a_jk: assert property (p_jk) else $error("first stage J-K mismatch"); // RULE6 RULE7

    property p_clear;
        @(posedge core_clk) disable iff (!rst_n)
        !clear_n_s |=> stages_q == 4'h0 && stage_four_out_inverted;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not force outputs"); // RULE8

    property p_inv;
        @(posedge core_clk) disable iff (!rst_n)
        stage_four_out_inverted != stage_four_out;
    endproperty
    a_inv: assert property (p_inv) else $error("inverted output not complementary"); // RULE9

    property p_clear_held;
        @(posedge core_clk) disable iff (!rst_n)
        (!clear_n_s) [*2] |-> stages_q == 4'h0;
    endproperty
    a_clear_held: assert property (p_clear_held) else $error("stages moved under clear"); // RULE8

    property p_mode_legal;
        @(posedge core_clk) disable iff (!rst_n)
        $onehot(mode);
    endproperty
    a_mode_legal: assert property (p_mode_legal) else $error("illegal mode"); // RULE10

    sequence s_two_shifts;
        s_shift_edge ##1 s_shift_edge;
    endsequence

    property p_two_shift;
        @(posedge core_clk) disable iff (!rst_n)
        s_two_shifts |=> stages_q[2] == $past(stages_q[0], 2);
    endproperty
    a_two_shift: assert property (p_two_shift) else $error("two shifts did not reach stage three"); // RULE5

    property p_load_inv;
        @(posedge core_clk) disable iff (!rst_n)
        s_load_edge |=> stage_four_out_inverted == !$past(data_s[3]);
    endproperty
    a_load_inv: assert property (p_load_inv) else $error("inverted output wrong after load"); // RULE9

    // ****************************************
    // Pin to output checks
    // ****************************************
    // Three edges: two synchroniser flops, then the stage register
    sequence s_pin_load;
        clear_n && !shift_not_load;
    endsequence

    sequence s_pin_shift;
        clear_n && shift_not_load;
    endsequence

    property p_load_pin;
        @(posedge core_clk) disable iff (!rst_n)
        s_pin_load |-> ##3 (stages_q == $past(data_in, 3));
    endproperty
    a_load_pin: assert property (p_load_pin) else $error("parallel data did not reach the stages"); // RULE2 RULE3

    property p_shift_pin;
        @(posedge core_clk) disable iff (!rst_n)
        s_pin_shift |-> ##3 (stages_q[3:1] == $past(stages_q[2:0]));
    endproperty
    a_shift_pin: assert property (p_shift_pin) else $error("shift request did not move the stages"); // RULE5

    property p_clear_pin_stages;
        @(posedge core_clk) disable iff (!rst_n)
        !clear_n |-> ##3 (stages_q == shift_reg_pkg::STAGES_RESET);
    endproperty
    a_clear_pin_stages: assert property (p_clear_pin_stages) else $error("clear pin left a stage high"); // RULE8

    property p_clear_pin_inv;
        @(posedge core_clk) disable iff (!rst_n)
        !clear_n |-> ##3 stage_four_out_inverted;
    endproperty
    a_clear_pin_inv: assert property (p_clear_pin_inv) else $error("clear pin left inverted output low"); // RULE8

endmodule
`default_nettype wire

/* File: verif/ctrl_driver.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Control side driver
// ****
module ctrl_driver (
    input wire logic core_clk,
    output logic clear_n,
    output logic shift_not_load,
    output shift_reg_pkg::serial_pair_t serial,
    output logic [3:0] data_in
);
    initial begin
        clear_n = 1'h1;
        shift_not_load = 1'h0;
        serial = 2'h0;
        data_in = 4'h0;
    end
    // Changes just after an edge, stable for the whole cycle
    task automatic apply(input logic [7:0] op);
        @(posedge core_clk);
        #1;
        clear_n = op[7];
        shift_not_load = op[6];
        serial = op[5:4];
        data_in = op[3:0];
    endtask
endmodule
`default_nettype wire

/* File: verif/parallel_shift_reg_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module parallel_shift_reg_tb_top;
    logic core_clk = 1'h0;
    logic rst_n = 1'h0;
    logic clear_n, shift_not_load;
    shift_reg_pkg::serial_pair_t serial;
    logic [3:0] data_in, exp_q;
    logic [7:0] p1_q, p2_q;
    logic [4:0] seen;
    logic o1, o2, o3, o4, o4n;
    int bad_count = 0;
    int checks = 0;
    logic [7:0] ops [13] = '{8'h8a, 8'hb5, 8'hd0, 8'hc0, 8'hf0, 8'he0, 8'he0,
        8'h70, 8'hf0, 8'h8f, 8'he0, 8'h0f, 8'h83};
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    ctrl_driver i_drv (.core_clk(core_clk), .clear_n(clear_n), .shift_not_load(shift_not_load),
        .serial(serial), .data_in(data_in));
    parallel_shift_reg i_dut (.core_clk(core_clk), .rst_n(rst_n), .clear_n(clear_n),
        .shift_not_load(shift_not_load), .j_in(serial.j_in), .k_in_n(serial.k_in_n),
        .data_in(data_in), .stage_one_out(o1), .stage_two_out(o2), .stage_three_out(o3),
        .stage_four_out(o4), .stage_four_out_inverted(o4n));
    // ****
    // Reference with the two-flop input latency
    // ****
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            p1_q <= 8'h00;
            p2_q <= 8'h00;
            exp_q <= 4'h0;
        end else begin
            p1_q <= {clear_n, shift_not_load, serial, data_in};
            p2_q <= p1_q;
            if (!p2_q[7]) exp_q <= 4'h0;
            else if (!p2_q[6]) exp_q <= p2_q[3:0];
            else exp_q <= {exp_q[2:0], (p2_q[5] & ~exp_q[0]) | (p2_q[4] & exp_q[0])};
        end
    end
    assign seen = {o4, o3, o2, o1, o4n};
    task automatic check(input string what, input logic [4:0] got, input logic [4:0] want);
        checks++;
        if (got !== want) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, want, got);
        end
    endtask
    task automatic results();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        #5000;
        bad_count++;
        results();
    end
    // ****
    // Main sequence
    // ****
    initial begin
        repeat (3) @(posedge core_clk);
        #1;
        rst_n = 1'h1;
        for (int i = 0; i < 17; i++) begin
            i_drv.apply(ops[i < 13 ? i : 12]);
            @(posedge core_clk);
            #2;
            check("stages", seen, {exp_q, ~exp_q[3]});
        end
        results();
    end
endmodule
`default_nettype wire
